//--- src/pin_mux_pkg.sv
// Shared constants and types for the pin mode and function mux.
// Assumes a plain register port and a single system clock domain.
package pin_mux_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned ADDR_W    = 32;  // Register address width
  localparam int unsigned DATA_W    = 16;  // Register data width
  localparam int unsigned NUM_PINS  = 3;   // Pins handled here
  localparam int unsigned FIRST_PIN = 2;   // Port index of pin slot 0
  localparam int unsigned SYNC_LEN  = 3;   // Pin synchroniser depth

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] PIN2_MODE_ADDR = 32'h5000_300A;
  localparam logic [31:0] PIN3_MODE_ADDR = 32'h5000_300C;
  localparam logic [31:0] PIN4_MODE_ADDR = 32'h5000_300E;

  // ****************************************************************
  // Mode register fields
  // ****************************************************************
  localparam int unsigned PULL_DIRECTION_FIELD_LSB = 8;   // pull_direction_field
  localparam int unsigned PULL_DIRECTION_FIELD_W   = 2;
  localparam int unsigned FUNC_LSB = 0;   // pin_function_select
  localparam int unsigned FUNC_W   = 5;
  localparam logic [15:0] MODE_WMASK = 16'h031F;  // Writable bits

  // Direction and pull codes
  localparam logic [1:0] PULL_DIRECTION_FIELD_IN_FLOAT = 2'h0;
  localparam logic [1:0] PULL_DIRECTION_FIELD_IN_UP    = 2'h1;
  localparam logic [1:0] PULL_DIRECTION_FIELD_IN_DOWN  = 2'h2;
  localparam logic [1:0] PULL_DIRECTION_FIELD_OUT      = 2'h3;
  localparam logic [1:0] PULL_DIRECTION_FIELD_RESET    = 2'h2;  // Input, pull-down
  localparam logic [4:0] FUNC_RESET    = 5'h00; // Plain port

  // Highest port pin index that may take the restricted functions
  localparam int unsigned ANALOG_MAX_PIN = 3;
  localparam int unsigned DIAG_MAX_PIN   = 7;

  // ****************************************************************
  // Function codes
  // ****************************************************************
  typedef enum logic [4:0] {
    FN_PORT      = 5'h00,
    FN_S1_RX     = 5'h01,
    FN_S1_TX     = 5'h02,
    FN_S2_RX     = 5'h03,
    FN_S2_TX     = 5'h04,
    FN_SPI_DIN   = 5'h05,
    FN_SPI_DOUT  = 5'h06,
    FN_SPI_CLK   = 5'h07,
    FN_SPI_EN    = 5'h08,
    FN_TW_SCL    = 5'h09,
    FN_TW_SDA    = 5'h0A,
    FN_S1_IR_RX  = 5'h0B,
    FN_S1_IR_TX  = 5'h0C,
    FN_S2_IR_RX  = 5'h0D,
    FN_S2_IR_TX  = 5'h0E,
    FN_ANALOG    = 5'h0F,
    FN_PW0       = 5'h10,
    FN_PW1       = 5'h11,
    FN_DIAG      = 5'h12,
    FN_S1_CTS_N  = 5'h13,
    FN_S1_RTS_N  = 5'h14,
    FN_S2_CTS_N  = 5'h15,
    FN_S2_RTS_N  = 5'h16,
    FN_PW2       = 5'h17,
    FN_PW3       = 5'h18,
    FN_PW4       = 5'h19
  } pin_func_e;

  // ****************************************************************
  // Peripheral input slots
  // ****************************************************************
  localparam int unsigned IN_S1_RX    = 0;
  localparam int unsigned IN_S2_RX    = 1;
  localparam int unsigned IN_S1_IR_RX = 2;
  localparam int unsigned IN_S2_IR_RX = 3;
  localparam int unsigned IN_S1_CTS_N = 4;
  localparam int unsigned IN_S2_CTS_N = 5;
  localparam int unsigned IN_SPI_DIN  = 6;
  localparam int unsigned IN_TW_SCL   = 7;
  localparam int unsigned IN_TW_SDA   = 8;
  localparam int unsigned NUM_IN      = 9;

  // Levels driven by the peripherals toward the pins
  typedef struct packed {
    logic       s1_tx;
    logic       s2_tx;
    logic       s1_ir_tx;
    logic       s2_ir_tx;
    logic       s1_rts_n;
    logic       s2_rts_n;
    logic       spi_dout;
    logic       spi_clk;
    logic       spi_en;
    logic [4:0] pulse_width;   // Pulse-width outputs zero to four
    logic       radio_diag;
    logic       tw_scl;        // 0 pulls the line low, 1 releases
    logic       tw_sda;
  } periph_out_s;

  // Input claims and levels of one group of pins
  typedef struct packed {
    logic [NUM_IN-1:0] claim;
    logic [NUM_IN-1:0] level;
  } in_chain_s;

  // Pad controls of one pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_down;
    logic analog_en;
  } pad_ctrl_s;

endpackage

//--- src/pin_level_sync.sv
// Three-stage synchroniser for one pin level with an agreement filter.
// Assumes an asynchronous pin on the input side.
`timescale 1ns/1ns
module pin_level_sync
  import pin_mux_pkg::*;
(
  input  wire logic mclk_i,   // System clock
  input  wire logic rst_b_i,  // Asynchronous reset, active low
  input  wire logic pin_i,    // Raw pin level
  output logic      level_o   // Filtered level
);

  logic [SYNC_LEN-1:0] stage_q;  // Stage 0 is read only by stage 1
  logic                level_q;  // Accepted level

  // ****************************************************************
  // Sampling chain
  // ****************************************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[SYNC_LEN-2:0], pin_i};
    end
  end

  // Accept a change once the last two stages agree
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_q <= stage_q[2];
    end
  end

  assign level_o = level_q;

endmodule // pin_level_sync

//--- src/pin_mode_cell.sv
// Function decode and pad control of one port pin.
// Assumes mode fields from registers and a synchronised pin level.
`timescale 1ns/1ns
module pin_mode_cell
  import pin_mux_pkg::*;
#(
  parameter int unsigned PIN_INDEX = 2  // Index within the first port
) (
  input  wire logic [1:0]  pull_direction_field_i,      // pull_direction_field
  input  wire logic [4:0]  func_i,      // pin_function_select
  input  wire periph_out_s periph_i,    // Peripheral output levels
  input  wire logic        gpio_out_i,  // Plain port output value
  input  wire logic        level_i,     // Synchronised pin level
  output pad_ctrl_s        pad_o,       // Pad controls
  output logic [NUM_IN-1:0] claim_o     // Input functions taken
);

  // ****************************************************************
  // Effective function
  // ****************************************************************
  localparam logic ANALOG_OK = (PIN_INDEX <= ANALOG_MAX_PIN);
  localparam logic DIAG_OK   = (PIN_INDEX <= DIAG_MAX_PIN);

  wire logic reserved_code = (func_i > FN_PW4);
  wire logic analog_bad = (func_i == FN_ANALOG) && !ANALOG_OK;
  wire logic diag_bad   = (func_i == FN_DIAG) && !DIAG_OK;
  wire logic to_port    = reserved_code || analog_bad || diag_bad;
  wire pin_func_e func  = to_port ? FN_PORT : pin_func_e'(func_i);

  // Plain port direction and pulls
  wire logic port_oe  = (pull_direction_field_i == PULL_DIRECTION_FIELD_OUT);
  wire logic port_up  = (pull_direction_field_i == PULL_DIRECTION_FIELD_IN_UP);
  wire logic port_dn  = (pull_direction_field_i == PULL_DIRECTION_FIELD_IN_DOWN);

  // ****************************************************************
  // Routing
  // ****************************************************************
  // Drive a peripheral output onto the pin
  function automatic pad_ctrl_s drive(input logic v);
    pad_ctrl_s p;
    p = '0;
    p.out = v;
    p.oe  = 1'b1;
    return p;
  endfunction

  // Input function: pad released, pulls as the field says
  pad_ctrl_s listen;
  assign listen = '{out: 1'b0, oe: 1'b0, pull_up: port_up,
                    pull_down: port_dn, analog_en: 1'b0};

  always_comb begin
    pad_o   = '{out: gpio_out_i, oe: port_oe, pull_up: port_up,
                pull_down: port_dn, analog_en: 1'b0};
    claim_o = '0;
    unique case (func)
      FN_PORT:     pad_o = pad_o;
      FN_S1_RX:    begin pad_o = listen; claim_o[IN_S1_RX] = 1'b1; end
      FN_S1_TX:    pad_o = drive(periph_i.s1_tx);
      FN_S2_RX:    begin pad_o = listen; claim_o[IN_S2_RX] = 1'b1; end
      FN_S2_TX:    pad_o = drive(periph_i.s2_tx);
      FN_SPI_DIN:  begin
        pad_o = listen;
        claim_o[IN_SPI_DIN] = 1'b1;
      end
      FN_SPI_DOUT: pad_o = drive(periph_i.spi_dout);
      FN_SPI_CLK:  pad_o = drive(periph_i.spi_clk);
      FN_SPI_EN:   pad_o = drive(periph_i.spi_en);
      FN_TW_SCL:   begin
        // Open drain: pulls off while pulling low, line listened to
        pad_o = periph_i.tw_scl ? listen : drive(1'b0);
        claim_o[IN_TW_SCL] = 1'b1;
      end
      FN_TW_SDA:   begin
        pad_o = periph_i.tw_sda ? listen : drive(1'b0);
        claim_o[IN_TW_SDA] = 1'b1;
      end
      FN_S1_IR_RX: begin
        pad_o = listen;
        claim_o[IN_S1_IR_RX] = 1'b1;
      end
      FN_S1_IR_TX: pad_o = drive(periph_i.s1_ir_tx);
      FN_S2_IR_RX: begin
        pad_o = listen;
        claim_o[IN_S2_IR_RX] = 1'b1;
      end
      FN_S2_IR_TX: pad_o = drive(periph_i.s2_ir_tx);
      FN_ANALOG:   begin
        // Direction and pulls ignored, pad handed to the converter
        pad_o = '0;
        pad_o.analog_en = 1'b1;
      end
      FN_PW0:      pad_o = drive(periph_i.pulse_width[0]);
      FN_PW1:      pad_o = drive(periph_i.pulse_width[1]);
      FN_DIAG:     pad_o = drive(periph_i.radio_diag);
      FN_S1_CTS_N: begin
        pad_o = listen;
        claim_o[IN_S1_CTS_N] = 1'b1;
      end
      FN_S1_RTS_N: pad_o = drive(periph_i.s1_rts_n);
      FN_S2_CTS_N: begin
        pad_o = listen;
        claim_o[IN_S2_CTS_N] = 1'b1;
      end
      FN_S2_RTS_N: pad_o = drive(periph_i.s2_rts_n);
      FN_PW2:      pad_o = drive(periph_i.pulse_width[2]);
      FN_PW3:      pad_o = drive(periph_i.pulse_width[3]);
      FN_PW4:      pad_o = drive(periph_i.pulse_width[4]);
      default:     pad_o = pad_o;
    endcase
  end

  // Unused: level_i is folded in by the caller through claim_o

endmodule // pin_mode_cell

//--- src/port_pin_mode_mux.sv
// Mode registers and function mux for pins 2 to 4 of the first port.
// Assumes a plain register port on the system clock, pins arriving
// asynchronously, and priority chains from the neighbouring pin groups.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module port_pin_mode_mux
  import pin_mux_pkg::*;
(
  input  wire logic              mclk_i,              // System clock
  input  wire logic              rst_b_i,             // Reset, active low
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,              // Byte address
  input  wire logic [DATA_W-1:0] wdata_i,             // Write data
  input  wire logic              wr_i,                // Write strobe
  input  wire logic              rd_i,                // Read strobe
  output logic [DATA_W-1:0]      rdata_o,             // Read data
  // Pads
  input  wire logic [NUM_PINS-1:0] pin_level_i,       // Raw pin levels
  output pad_ctrl_s [NUM_PINS-1:0] pad_ctrl_o,        // Pad controls
  // Plain port function
  input  wire logic [NUM_PINS-1:0] gpio_out_i,        // Port out values
  output logic [NUM_PINS-1:0]      gpio_in_o,         // Port in values
  // Peripherals
  input  wire periph_out_s         periph_out_i,      // Toward pins
  input  wire in_chain_s           lower_pins_i,      // Pins 0 and 1
  input  wire in_chain_s           upper_pins_i,      // Pins 5 and up
  input  wire in_chain_s           second_port_i,     // Second port
  output in_chain_s                periph_in_o        // Resolved inputs
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [DATA_W-1:0] mode_q [NUM_PINS];   // Mode registers
  logic [DATA_W-1:0] rdata_q;             // Read data stage

  // Reset value of each mode register
  localparam logic [DATA_W-1:0] MODE_RESET =
    DATA_W'({PULL_DIRECTION_FIELD_RESET, 3'h0, FUNC_RESET});

  // Address decode
  wire logic hit_pin2 = (addr_i == PIN2_MODE_ADDR);
  wire logic hit_pin3 = (addr_i == PIN3_MODE_ADDR);
  wire logic hit_pin4 = (addr_i == PIN4_MODE_ADDR);
  wire logic [NUM_PINS-1:0] hit = {hit_pin4, hit_pin3, hit_pin2};

  // Masked write value, reserved bits kept at zero
  wire logic [DATA_W-1:0] wr_value = wdata_i & MODE_WMASK;

  // Read selection, unmapped addresses read zero
  wire logic [DATA_W-1:0] rd_value =
      hit_pin2 ? mode_q[0] :
      hit_pin3 ? mode_q[1] :
      hit_pin4 ? mode_q[2] : '0;

  // Mode register storage
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        mode_q[i] <= MODE_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (wr_i && hit[i]) begin
          mode_q[i] <= wr_value;
        end
      end
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_i ? rd_value : '0;
    end
  end

  assign rdata_o = rdata_q;

  // ****************************************************************
  // Per-pin logic
  // ****************************************************************
  logic      [NUM_PINS-1:0] level;        // Synchronised pin levels
  pad_ctrl_s [NUM_PINS-1:0] pad_d;        // Pad controls, next
  pad_ctrl_s [NUM_PINS-1:0] pad_q;        // Pad controls, held
  logic      [NUM_IN-1:0]   claim [NUM_PINS]; // Input claims per pin

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    // Pin level synchroniser
    pin_level_sync u_sync (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .pin_i   (pin_level_i[p]),
      .level_o (level[p])
    );

    // Function decode for this pin
    pin_mode_cell #(
      .PIN_INDEX (FIRST_PIN + p)
    ) u_cell (
      .pull_direction_field_i     (mode_q[p][PULL_DIRECTION_FIELD_LSB +: PULL_DIRECTION_FIELD_W]),
      .func_i     (mode_q[p][FUNC_LSB +: FUNC_W]),
      .periph_i   (periph_out_i),
      .gpio_out_i (gpio_out_i[p]),
      .level_i    (level[p]),
      .pad_o      (pad_d[p]),
      .claim_o    (claim[p])
    );
  end

  // ****************************************************************
  // Input priority within this group
  // ****************************************************************
  in_chain_s own;   // Winner among pins 2 to 4

  // Walk from the highest pin down so the lowest index wins
  always_comb begin
    own = '0;
    for (int p = NUM_PINS - 1; p >= 0; p--) begin
      for (int f = 0; f < NUM_IN; f++) begin
        if (claim[p][f]) begin
          own.claim[f] = 1'b1;
          own.level[f] = level[p];
        end
      end
    end
  end

  // ****************************************************************
  // Input priority across groups and ports
  // ****************************************************************
  in_chain_s merged;   // Resolved input claims and levels

  always_comb begin
    merged = '0;
    for (int f = 0; f < NUM_IN; f++) begin
      merged.claim[f] = lower_pins_i.claim[f] | own.claim[f] |
                        upper_pins_i.claim[f] | second_port_i.claim[f];
      if (lower_pins_i.claim[f]) begin
        merged.level[f] = lower_pins_i.level[f];
      end else if (own.claim[f]) begin
        merged.level[f] = own.level[f];
      end else if (upper_pins_i.claim[f]) begin
        merged.level[f] = upper_pins_i.level[f];
      end else begin
        merged.level[f] = second_port_i.level[f];
      end
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  in_chain_s                periph_in_q;  // Registered peripheral inputs
  logic      [NUM_PINS-1:0] gpio_in_q;    // Registered port inputs

  // Safe pad state while in reset: input with pull-down
  localparam pad_ctrl_s PAD_RESET = '{out: 1'b0, oe: 1'b0,
    pull_up: 1'b0, pull_down: 1'b1, analog_en: 1'b0};

  // Pads and inputs registered so every data output comes from a flop
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pad_q       <= {NUM_PINS{PAD_RESET}};
      periph_in_q <= '0;
      gpio_in_q   <= '0;
    end else begin
      pad_q       <= pad_d;
      periph_in_q <= merged;
      gpio_in_q   <= level;
    end
  end

  assign pad_ctrl_o  = pad_q;
  assign periph_in_o = periph_in_q;
  assign gpio_in_o   = gpio_in_q;

endmodule // port_pin_mode_mux

//--- sim/port_pin_mode_mux_chk.sv
// Port checker of the pin mode mux: register port and pad controls.
// Assumes the single clock and active-low reset of the bound block.
`timescale 1ns/1ns
module port_pin_mode_mux_chk
  import pin_mux_pkg::*;
(
  input wire logic                mclk_i,
  input wire logic                rst_b_i,
  input wire logic [ADDR_W-1:0]   addr_i,
  input wire logic [DATA_W-1:0]   wdata_i,
  input wire logic                wr_i,
  input wire logic                rd_i,
  input wire logic [DATA_W-1:0]   rdata_o,
  input wire pad_ctrl_s [NUM_PINS-1:0] pad_ctrl_o,
  input wire logic [NUM_PINS-1:0] gpio_out_i,
  input wire periph_out_s         periph_out_i,
  input wire in_chain_s           lower_pins_i,
  input wire in_chain_s           periph_in_o
);
  // ************
  // Properties
  // ************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Reserved bits always read zero
  property p_rd_mask;
    rd_i |=> (rdata_o & ~MODE_WMASK) == '0;
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("reserved bits read nonzero");
  // Read right after a write returns the masked write
  property p_wr_rd;
    wr_i && addr_i == PIN3_MODE_ADDR ##1 rd_i && addr_i == PIN3_MODE_ADDR
    |=> rdata_o == ($past(wdata_i, 2) & MODE_WMASK);
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("read-back differs from write");
  // Analog pad has no driver and no pulls
  property p_analog;
    pad_ctrl_o[0].analog_en |-> pad_ctrl_o[0][4:1] == 4'h0;
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog pad still driven or pulled");
  // Pin 4 never takes the analog function
  property p_no_an4;
    !pad_ctrl_o[2].analog_en;
  endproperty
  a_no_an4: assert property (p_no_an4)
    else $error("analog enabled on pin 4");
  // A driven pad has its pulls off
  property p_oe_pull;
    pad_ctrl_o[1].oe |-> !pad_ctrl_o[1].pull_up && !pad_ctrl_o[1].pull_down;
  endproperty
  a_oe_pull: assert property (p_oe_pull)
    else $error("pull active while driving");
  // Lower pins win every input slot they claim
  property p_lower;
    ((periph_in_o.level ^ $past(lower_pins_i.level))
      & $past(lower_pins_i.claim)) == '0;
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower pin level not passed");
  // Reserved code with output field drives the port value
  property p_port_out;
    wr_i && addr_i == PIN2_MODE_ADDR && wdata_i[9:8] == 2'h3
      && wdata_i[4:0] > 5'h19 ##1 !wr_i
    |=> pad_ctrl_o[0] == {$past(gpio_out_i[0]), 4'h8};
  endproperty
  a_port_out: assert property (p_port_out)
    else $error("port output mode wrong");
  // Reserved code with pull-up field is a pulled-up input
  property p_rsv_in;
    wr_i && addr_i == PIN3_MODE_ADDR && wdata_i[9:8] == 2'h1
      && wdata_i[4:0] > 5'h19 ##1 !wr_i
    |=> pad_ctrl_o[1][3:0] == 4'h4;
  endproperty
  a_rsv_in: assert property (p_rsv_in)
    else $error("reserved code not plain input");
  // Code 16 drives pulse-width output zero
  property p_pw;
    wr_i && addr_i == PIN3_MODE_ADDR && wdata_i[4:0] == 5'h10 ##1 !wr_i
    |=> pad_ctrl_o[1] == {$past(periph_out_i.pulse_width[0]), 4'h8};
  endproperty
  a_pw: assert property (p_pw)
    else $error("pulse-width zero not routed");
endmodule // port_pin_mode_mux_chk

bind port_pin_mode_mux port_pin_mode_mux_chk i_port_pin_mode_mux_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pad_ctrl_o(pad_ctrl_o), .gpio_out_i(gpio_out_i),
  .periph_out_i(periph_out_i), .lower_pins_i(lower_pins_i),
  .periph_in_o(periph_in_o));

//--- sim/board_pin_model.sv
// Board side of pins 2 to 4: pad drivers, pulls and outside sources.
// Assumes the bench says which pins an outside source drives.
`timescale 1ns/1ns
module board_pin_model
  import pin_mux_pkg::*;
(
  input  wire logic                mclk_i,    // System clock
  input  wire pad_ctrl_s [NUM_PINS-1:0] pad_i, // Pad controls
  input  wire logic [NUM_PINS-1:0] ext_en_i,  // Outside source on
  input  wire logic [NUM_PINS-1:0] ext_val_i, // Outside level
  output logic [NUM_PINS-1:0]      pin_o      // Wire levels
);
  logic flt_q;  // Floating line, toggles so no level is trusted
  initial flt_q = 1'b0;
  always @(posedge mclk_i) begin
    flt_q <= ~flt_q;
  end
  // Pad driver first, then outside source, then pulls
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pad_i[i].oe) pin_o[i] = pad_i[i].out;
      else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
      else if (pad_i[i].pull_up) pin_o[i] = 1'b1;
      else if (pad_i[i].pull_down) pin_o[i] = 1'b0;
      else pin_o[i] = flt_q;
    end
  end
endmodule // board_pin_model

//--- sim/port_pin_mode_mux_test.sv
// Bench of the pin mode mux: register rows, every function code,
// a mid-run reset and input priority across pins and ports.
// Assumes the board model on the pads and the bound port checker.
`timescale 1ns/1ns
module port_pin_mode_mux_test
  import pin_mux_pkg::*;
;
  // ************
  // Signals
  // ************
  localparam logic [16:0] PAT = 17'h0AAA8;  // Peripheral level pattern
  typedef struct packed {
    logic [31:0] a;  // Address
    logic [15:0] d;  // Write data
    logic [15:0] r;  // Expected read-back
  } row_s;
  logic                     mclk_i, rst_b_i, wr_i, rd_i;
  logic [ADDR_W-1:0]        addr_i;
  logic [DATA_W-1:0]        wdata_i, rdata_o, q, d;
  logic [NUM_PINS-1:0]      pin_lvl, gpio_out_i, gpio_in_o, ext_en, ext_val;
  logic [3:0]               sl;
  pad_ctrl_s [NUM_PINS-1:0] pad_ctrl_o;
  periph_out_s              periph_out_i;
  in_chain_s                lower_pins_i, upper_pins_i, second_port_i;
  in_chain_s                periph_in_o;
  int                       bad_count = 0;
  int                       check_count = 0;
  row_s rows [7] = '{
    '{PIN2_MODE_ADDR, 16'hFFFF, 16'h031F},  // Reserved code, output
    '{PIN4_MODE_ADDR, 16'h000F, 16'h000F},  // Analog refused on pin 4
    '{PIN2_MODE_ADDR, 16'h030F, 16'h030F},  // Analog, field ignored
    '{PIN3_MODE_ADDR, 16'h0212, 16'h0212},  // Radio diagnostic
    '{PIN4_MODE_ADDR, 16'h0210, 16'h0210},  // Pulse-width zero
    '{32'h5000_3010, 16'hFFFF, 16'h0000},   // Unmapped place
    '{PIN3_MODE_ADDR, 16'h0200, 16'h0200}}; // Back to pull-down

  port_pin_mode_mux i_port_pin_mode_mux (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_level_i(pin_lvl), .pad_ctrl_o(pad_ctrl_o),
    .gpio_out_i(gpio_out_i), .gpio_in_o(gpio_in_o),
    .periph_out_i(periph_out_i), .lower_pins_i(lower_pins_i),
    .upper_pins_i(upper_pins_i), .second_port_i(second_port_i),
    .periph_in_o(periph_in_o));
  board_pin_model i_board_pin_model (.mclk_i(mclk_i), .pad_i(pad_ctrl_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin_lvl));

  // ************
  // Tasks
  // ************
  task automatic fail(string m);
    bad_count++;
    $display("[FAIL] %0t ns: %s", $time, m);
  endtask
  task automatic chk_reg(logic [15:0] g, logic [15:0] e);
    check_count++;
    if (g !== e) fail($sformatf("register %h, expected %h", g, e));
  endtask
  // Output value only compared when the pad should drive
  task automatic chk_pad(logic [4:0] g, logic [4:0] e);
    check_count++;
    if ((g & {e[3], 4'hF}) !== (e & {e[3], 4'hF}))
      fail($sformatf("pad %b, expected %b", g, e));
  endtask
  task automatic chk_bit(logic g, logic e);
    check_count++;
    if (g !== e) fail("peripheral input level");
  endtask
  // Optional write, then a read of the same place right after
  task automatic acc(logic [31:0] a, logic [15:0] v, bit w,
                     output logic [15:0] r);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= w;
    rd_i    <= !w;
    if (w) begin
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
    end
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask
  // Expected pad controls of one pin for a mode value
  function automatic logic [4:0] exp_pad(int pin, logic [15:0] m,
                                         periph_out_s p, logic g);
    if (m[4:0] == 5'd15 && pin <= 3) return 5'h01;
    case (m[4:0])
      5'd2: return {p.s1_tx, 4'h8};
      5'd4: return {p.s2_tx, 4'h8};
      5'd6: return {p.spi_dout, 4'h8};
      5'd7: return {p.spi_clk, 4'h8};
      5'd8: return {p.spi_en, 4'h8};
      5'd9, 5'd10: return 5'h08;  // Two-wire lines held low here
      5'd12: return {p.s1_ir_tx, 4'h8};
      5'd14: return {p.s2_ir_tx, 4'h8};
      5'd16: return {p.pulse_width[0], 4'h8};
      5'd17: return {p.pulse_width[1], 4'h8};
      5'd18: return {p.radio_diag, 4'h8};
      5'd20: return {p.s1_rts_n, 4'h8};
      5'd22: return {p.s2_rts_n, 4'h8};
      5'd23: return {p.pulse_width[2], 4'h8};
      5'd24: return {p.pulse_width[3], 4'h8};
      5'd25: return {p.pulse_width[4], 4'h8};
      default: ;
    endcase
    if (m[9:8] == 2'h3 && (m[4:0] == 5'd0 || m[4:0] > 5'd25))
      return {g, 4'h8};
    return {g, 1'b0, m[9:8] == 2'h1, m[9:8] == 2'h2, 1'b0};
  endfunction
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************
  // Clock, watchdog and sequence
  // ************
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    #400000;
    fail("run did not end");
    stop_test();
  end
  initial begin
    rst_b_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    gpio_out_i = 3'b101;
    periph_out_i = PAT;
    lower_pins_i = '0;
    upper_pins_i = '0;
    second_port_i = '0;
    ext_en = '0;
    ext_val = '0;
    repeat (8) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    // Register rows on all three pins
    foreach (rows[i]) begin
      acc(rows[i].a, rows[i].d, 1'b1, q);
      chk_reg(q, rows[i].r);
      sl = rows[i].a[3:0] - 4'hA;
      @(posedge mclk_i);
      #1 if (sl[3:1] < 3) chk_pad(pad_ctrl_o[sl[2:1]], exp_pad(FIRST_PIN
        + sl[3:1], rows[i].d, periph_out_i, gpio_out_i[sl[2:1]]));
    end
    // Every function code on pin 3, pattern then its inverse
    for (int k = 0; k < 64; k++) begin
      d = {6'h0, 2'h1, 3'h0, k[4:0]};
      @(posedge mclk_i);
      periph_out_i <= k[5] ? (~PAT & 17'h1FFFC) : PAT;
      acc(PIN3_MODE_ADDR, d, 1'b1, q);
      chk_reg(q, d);
      @(posedge mclk_i);
      #1 chk_pad(pad_ctrl_o[1], exp_pad(3, d, periph_out_i, gpio_out_i[1]));
    end
    // Reset in mid-run, then reset values
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    for (int i = 0; i < NUM_PINS; i++) chk_pad(pad_ctrl_o[i], 5'h02);
    rst_b_i <= 1'b1;
    for (int i = 0; i < NUM_PINS; i++) begin
      acc(PIN2_MODE_ADDR + 32'(2 * i), 16'h0, 1'b0, q);
      chk_reg(q, 16'h0200);
    end
    // Same input on pins 2 and 3, then other claimants
    @(posedge mclk_i);
    ext_en  <= 3'b011;
    ext_val <= 3'b001;
    acc(PIN3_MODE_ADDR, 16'h0005, 1'b1, q);
    acc(PIN2_MODE_ADDR, 16'h0005, 1'b1, q);
    acc(PIN4_MODE_ADDR, 16'h0100, 1'b1, q);
    repeat (6) @(posedge mclk_i);
    #1 chk_bit(periph_in_o.level[IN_SPI_DIN], 1'b1);
    chk_bit(periph_in_o.claim[IN_SPI_DIN], 1'b1);
    chk_bit(gpio_in_o[2], 1'b1);
    @(posedge mclk_i);
    second_port_i <= {9'h0C0, 9'h000};
    upper_pins_i  <= {9'h080, 9'h080};
    repeat (2) @(posedge mclk_i);
    #1 chk_bit(periph_in_o.level[IN_SPI_DIN], 1'b1);
    chk_bit(periph_in_o.level[IN_TW_SCL], 1'b1);
    @(posedge mclk_i);
    lower_pins_i <= {9'h040, 9'h000};
    repeat (2) @(posedge mclk_i);
    #1 chk_bit(periph_in_o.level[IN_SPI_DIN], 1'b0);
    stop_test();
  end
endmodule // port_pin_mode_mux_test
